/* design/dctcm_consts.svh */
`ifndef DCTCM_CONSTS_SVH
`define DCTCM_CONSTS_SVH

// Clock rate in kHz, so that a time in milliseconds times this gives cycles.
`define DCTCM_CLK_KHZ        100000
// Longest spread between the two channels that still counts as a paired removal.
`define DCTCM_PAIR_WINDOW_MS 1000
// Longest time one channel may stay low alone before the fault latch sets.
`define DCTCM_SINGLE_MS      3000
// Default speed decrement per clock during a controlled stop.
`define DCTCM_RAMP_STEP      1
// Depth of the input synchroniser.
`define DCTCM_SYNC_DEPTH     3

`endif

/* design/dctcm_pkg.sv */
package dctcm_pkg;

  // Drive motion state.
  typedef enum logic [1:0]
  {
    DCTCM_STOPPED = 2'b00,
    DCTCM_RUNNING = 2'b01,
    DCTCM_DECEL   = 2'b10
  } dctcm_state_type;

endpackage

/* design/dctcm_monitor.sv */
`include "dctcm_consts.svh"

// Behaviour
// - After reset with both inputs high: trip set until restart; feedback contact closed for four clocks, then open.
// - One input dropping cuts power and trips at once; feedback stays open.
// - With both inputs high, restart clears the trip and runs at setpoint.
// - One input low over 3 s alone cuts power, trips and latches fault.
// - While the fault is latched, restart does nothing; trip persists, feedback open.
// - Only power cycling clears the fault; afterwards feedback closed for four clocks, then open; restart works.
// - Stop command with inputs high ramps speed down, no cutoff, feedback open.
// - Both inputs removed within 1 s close feedback, without latching the fault.
// - With both inputs removed, run commands never start the drive; trip stays.
// - Both inputs restored after paired removal open the feedback at once.
// - After paired removal and restore, restart clears trip and runs, no power cycle.
// - Feedback contact closes only when the cutoff is invoked on both channels, and for four clocks after reset.
module dctcm_monitor
#(
  parameter int unsigned SPEED_W      = 16,
  parameter int unsigned PAIR_CYCLES  = `DCTCM_PAIR_WINDOW_MS * `DCTCM_CLK_KHZ,
  parameter int unsigned LIMIT_CYCLES = `DCTCM_SINGLE_MS * `DCTCM_CLK_KHZ,
  parameter int unsigned RAMP_STEP    = `DCTCM_RAMP_STEP
)
(
  // Clock and power-on reset.
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Safety demand pins, high while 24 V is applied.
  input  wire logic               safety_input_a,
  input  wire logic               safety_input_b,
  // Drive commands from control logic on the same clock.
  input  wire logic               run_request,
  input  wire logic               stop_request,
  input  wire logic [SPEED_W-1:0] test_speed_setpoint,
  // Drive and status outputs.
  output logic                    motor_power_q,
  output logic [SPEED_W-1:0]      speed_demand_q,
  output logic                    cutoff_trip_q,
  output logic                    fault_latch_q,
  output logic                    feedback_contact_q
);

  // The limits must be ordered and fit the 32-bit timer.
  initial
  begin
    if (PAIR_CYCLES < 1 || LIMIT_CYCLES <= PAIR_CYCLES || SPEED_W < 1 || RAMP_STEP < 1)
      $error("dctcm_monitor: illegal parameter values");
  end

  localparam logic [SPEED_W-1:0] STEP = SPEED_W'(RAMP_STEP);

  // Three-stage synchronisers; a level is accepted once stages two and three agree.
  logic [`DCTCM_SYNC_DEPTH-1:0] sync_a_q;
  logic [`DCTCM_SYNC_DEPTH-1:0] sync_b_q;
  logic [`DCTCM_SYNC_DEPTH-1:0] sync_a_d;
  logic [`DCTCM_SYNC_DEPTH-1:0] sync_b_d;
  logic                         level_a_q;
  logic                         level_b_q;
  logic                         level_a_d;
  logic                         level_b_d;

  // Accepted levels only move when the last two stages agree, which filters single-cycle glitches.
  always_comb
  begin
    sync_a_d  = {sync_a_q[`DCTCM_SYNC_DEPTH-2:0], safety_input_a};
    sync_b_d  = {sync_b_q[`DCTCM_SYNC_DEPTH-2:0], safety_input_b};
    level_a_d = level_a_q;
    level_b_d = level_b_q;
    if (sync_a_q[1] == sync_a_q[2])
      level_a_d = sync_a_q[2];
    if (sync_b_q[1] == sync_b_q[2])
      level_b_d = sync_b_q[2];
  end

  // Levels reset low so the drive starts cut off until both inputs are seen high.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a_q  <= '0;
      sync_b_q  <= '0;
      level_a_q <= 1'b0;
      level_b_q <= 1'b0;
    end
    else
    begin
      sync_a_q  <= sync_a_d;
      sync_b_q  <= sync_b_d;
      level_a_q <= level_a_d;
      level_b_q <= level_b_d;
    end
  end

  logic both_high;
  logic both_low;
  logic one_low;

  // Channel condition summary.
  assign both_high = level_a_q & level_b_q;
  assign both_low  = ~level_a_q & ~level_b_q;
  assign one_low   = level_a_q ^ level_b_q;

  // Supervision: single-channel timer, paired-removal flag, fault latch and trip flag.
  logic [31:0] single_cnt_q;
  logic [31:0] single_cnt_d;
  logic        paired_q;
  logic        paired_d;
  logic        fault_d;
  logic        trip_d;
  logic        feedback_d;
  logic        restart_ok;

  assign restart_ok = run_request & both_high & ~fault_latch_q;

  // The timer runs while exactly one channel is low and saturates at the limit.
  // It also times the pairing window, so a second drop inside it marks a paired removal.
  always_comb
  begin
    single_cnt_d = single_cnt_q;
    paired_d     = paired_q;
    fault_d      = fault_latch_q;
    trip_d       = cutoff_trip_q;
    if (one_low)
    begin
      if (single_cnt_q < LIMIT_CYCLES)
        single_cnt_d = single_cnt_q + 32'h0000_0001;
    end
    else if (both_high)
      single_cnt_d = '0;
    // The contact needs both channels still low; one channel coming back alone reopens it.
    if (both_low && (paired_q || single_cnt_q <= PAIR_CYCLES))
      paired_d = 1'b1;
    else
      paired_d = 1'b0;
    if (one_low && single_cnt_q >= LIMIT_CYCLES)
      fault_d = 1'b1;
    // Restart clears the trip, but a live cutoff condition sets it again and wins.
    if (restart_ok)
      trip_d = 1'b0;
    if (!both_high || fault_latch_q)
      trip_d = 1'b1;
    feedback_d = paired_d & ~fault_d;
  end

  // Trip comes up set and fault clear: the drive is cut off until a clean restart.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      single_cnt_q       <= '0;
      paired_q           <= 1'b0;
      fault_latch_q      <= 1'b0;
      cutoff_trip_q      <= 1'b1;
      feedback_contact_q <= 1'b0;
    end
    else
    begin
      single_cnt_q       <= single_cnt_d;
      paired_q           <= paired_d;
      fault_latch_q      <= fault_d;
      cutoff_trip_q      <= trip_d;
      feedback_contact_q <= feedback_d;
    end
  end

  // Motion control: cutoff drops power at once; stop ramps speed to zero first.
  dctcm_pkg::dctcm_state_type state_q;
  dctcm_pkg::dctcm_state_type state_d;
  logic [SPEED_W-1:0]         speed_d;
  logic                       power_d;
  logic                       cutoff;

  assign cutoff = ~both_high | fault_latch_q;

  always_comb
  begin
    state_d = state_q;
    speed_d = speed_demand_q;
    unique case (state_q)
      dctcm_pkg::DCTCM_STOPPED:
      begin
        if (restart_ok)
        begin
          state_d = dctcm_pkg::DCTCM_RUNNING;
          speed_d = test_speed_setpoint;
        end
      end
      dctcm_pkg::DCTCM_RUNNING:
      begin
        speed_d = test_speed_setpoint;
        if (stop_request)
          state_d = dctcm_pkg::DCTCM_DECEL;
      end
      dctcm_pkg::DCTCM_DECEL:
      begin
        if (speed_demand_q <= STEP)
        begin
          speed_d = '0;
          state_d = dctcm_pkg::DCTCM_STOPPED;
        end
        else
          speed_d = speed_demand_q - STEP;
      end
      default:
      begin
        state_d = dctcm_pkg::DCTCM_STOPPED;
        speed_d = '0;
      end
    endcase
    // Coasting: power goes at the clock edge after the cutoff is seen.
    if (cutoff)
    begin
      state_d = dctcm_pkg::DCTCM_STOPPED;
      speed_d = '0;
    end
    power_d = (state_d != dctcm_pkg::DCTCM_STOPPED);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q        <= dctcm_pkg::DCTCM_STOPPED;
      speed_demand_q <= '0;
      motor_power_q  <= 1'b0;
    end
    else
    begin
      state_q        <= state_d;
      speed_demand_q <= speed_d;
      motor_power_q  <= power_d;
    end
  end

  // Checks on the design's own outputs.
  a_cutoff_kills_power: assert property (@(posedge clock) disable iff (!rst_n)
    !both_high |=> !motor_power_q && cutoff_trip_q)
    else $error("power present during cutoff");

  a_fault_latch_sticks: assert property (@(posedge clock) disable iff (!rst_n)
    fault_latch_q |=> fault_latch_q)
    else $error("fault latch cleared without reset");

  a_fault_sets_at_limit: assert property (@(posedge clock) disable iff (!rst_n)
    one_low && single_cnt_q >= LIMIT_CYCLES |=> fault_latch_q && !motor_power_q)
    else $error("fault not latched at limit");

  a_fault_blocks_run: assert property (@(posedge clock) disable iff (!rst_n)
    fault_latch_q |=> !motor_power_q && cutoff_trip_q && !feedback_contact_q)
    else $error("drive active with fault latched");

  a_feedback_needs_both: assert property (@(posedge clock) disable iff (!rst_n)
    feedback_contact_q |-> $past(both_low) && !fault_latch_q)
    else $error("feedback closed without dual cutoff");

  a_feedback_opens_fast: assert property (@(posedge clock) disable iff (!rst_n)
    both_high |=> !feedback_contact_q)
    else $error("feedback not opened on restore");

  a_pair_closes_feed: assert property (@(posedge clock) disable iff (!rst_n)
    both_low && single_cnt_q <= PAIR_CYCLES && !fault_latch_q |=> feedback_contact_q)
    else $error("paired removal not confirmed");

  a_restart_runs: assert property (@(posedge clock) disable iff (!rst_n)
    restart_ok && state_q == dctcm_pkg::DCTCM_STOPPED |=>
      motor_power_q && !cutoff_trip_q ##0 speed_demand_q == $past(test_speed_setpoint))
    else $error("restart did not run at setpoint");

  a_stop_ramps_down: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == dctcm_pkg::DCTCM_DECEL && !cutoff && speed_demand_q > STEP |=>
      motor_power_q && speed_demand_q == $past(speed_demand_q) - STEP && !feedback_contact_q)
    else $error("controlled stop did not ramp");

  a_reset_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> !feedback_contact_q && !fault_latch_q && !motor_power_q)
    else $error("outputs not quiet after reset");

  c_single_fault: cover property (@(posedge clock) disable iff (!rst_n) $rose(fault_latch_q));
  c_paired_cutoff: cover property (@(posedge clock) disable iff (!rst_n) $rose(feedback_contact_q));
  c_restart_run: cover property (@(posedge clock) disable iff (!rst_n) $rose(motor_power_q));
  c_ramp_stop: cover property (@(posedge clock) disable iff (!rst_n)
    state_q == dctcm_pkg::DCTCM_DECEL ##1 state_q == dctcm_pkg::DCTCM_STOPPED);

endmodule

/* bench/dctcm_safety_unit.sv */
// Stand-in for the external safety control unit driving both demand pins.
module dctcm_safety_unit
(
  // Clock and power-on reset.
  input  wire logic clock,
  input  wire logic rst_n,
  // Cutoff demands from the bench, high asks for removal.
  input  wire logic req_a,
  input  wire logic req_b,
  // Demand pins towards the drive, high while 24 V is applied.
  output logic      safety_input_a,
  output logic      safety_input_b
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pins sit at 24 V through power-up and follow a demand one clock later.
  // The bench keeps paired removals a few clocks apart, well inside the window.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      safety_input_a <= 1'b1;
      safety_input_b <= 1'b1;
    end
    else
    begin
      safety_input_a <= ~req_a;
      safety_input_b <= ~req_b;
    end
  end
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the torque cutoff monitor.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 30;
  localparam int PAIR  = 10;
  logic        clock, rst_n, req_a, req_b, run_request, stop_request;
  logic        safety_input_a, safety_input_b;
  logic        motor_power_q, cutoff_trip_q, fault_latch_q, feedback_contact_q;
  logic [15:0] test_speed_setpoint, speed_demand_q;
  int          miscompares, n_tests, seed, sp, m_pow, m_trip, m_fault, m_fb, m_spd, ma, mb;

  dctcm_safety_unit unit (.clock(clock), .rst_n(rst_n), .req_a(req_a), .req_b(req_b),
    .safety_input_a(safety_input_a), .safety_input_b(safety_input_b));

  dctcm_monitor #(.PAIR_CYCLES(PAIR), .LIMIT_CYCLES(LIMIT)) dut (.clock(clock), .rst_n(rst_n),
    .safety_input_a(safety_input_a), .safety_input_b(safety_input_b), .run_request(run_request),
    .stop_request(stop_request), .test_speed_setpoint(test_speed_setpoint),
    .motor_power_q(motor_power_q), .speed_demand_q(speed_demand_q), .cutoff_trip_q(cutoff_trip_q),
    .fault_latch_q(fault_latch_q), .feedback_contact_q(feedback_contact_q));

  // Free-running 100 MHz clock.
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Counts one comparison and reports a mismatch at once.
  task automatic cmp(input logic [19:0] exp_v, input logic [19:0] got_v);
    n_tests++;
    if (got_v !== exp_v)
    begin
      miscompares++;
      $display("[FAIL] %0t exp=%h got=%h", $time, exp_v, got_v);
    end
  endtask

  // Compares all outputs with the model, away from the clock edge so they are settled.
  task automatic check_state();
    @(negedge clock);
    cmp({m_pow[0], m_trip[0], m_fault[0], m_fb[0], m_spd[15:0]},
        {motor_power_q, cutoff_trip_q, fault_latch_q, feedback_contact_q, speed_demand_q});
  endtask

  // Power removal and reapplication; the model returns to its power-up state.
  task automatic power_cycle();
    @(posedge clock);
    rst_n <= 1'b0;
    tick(10);
    rst_n <= 1'b1;
    tick(6);
    m_pow = 0;
    m_spd = 0;
    m_trip = 1;
    m_fault = 0;
    m_fb = 0;
  endtask

  // One-cycle restart command; it only takes with both pins high and no latched fault.
  task automatic restart();
    @(posedge clock);
    run_request <= 1'b1;
    @(posedge clock);
    run_request <= 1'b0;
    if (ma + mb == 0 && m_fault == 0)
    begin
      m_pow = 1;
      m_spd = sp;
      m_trip = 0;
    end
  endtask

  // Sets both channel demands and holds them for a number of clocks.
  task automatic demand(input int a, input int b, input int hold);
    @(posedge clock);
    req_a <= a[0];
    req_b <= b[0];
    tick(hold);
    ma = a;
    mb = b;
    if (a + b > 0)
    begin
      m_pow = 0;
      m_spd = 0;
      m_trip = 1;
    end
    if (a + b == 1 && hold > LIMIT + 8) m_fault = 1;
    m_fb = (a + b == 2 && m_fault == 0) ? 1 : 0;
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog; the whole sequence needs well under two thousand clocks.
  initial
  begin
    #200000;
    miscompares++;
    end_sim();
  end

  // Main sequence.
  initial
  begin
    {miscompares, n_tests, ma, mb} = '0;
    seed = 31;
    {rst_n, req_a, req_b, run_request, stop_request} = '0;
    sp = ($random(seed) & 32'h0000_00FF) | 32'h0000_0010;
    test_speed_setpoint = sp[15:0];
    power_cycle();
    check_state();
    restart();
    check_state();
    for (int ch = 0; ch < 2; ch++)
    begin
      // A drop needs six clocks to reach the outputs: pin register, three stages, level register, output register.
      demand(ch == 0, ch == 1, 8);
      check_state();
      demand(0, 0, 8);
      restart();
      check_state();
    end
    for (int ch = 0; ch < 2; ch++)
    begin
      demand(ch == 0, ch == 1, LIMIT + 12);
      check_state();
      demand(0, 0, 8);
      restart();
      check_state();
      power_cycle();
      check_state();
      restart();
      check_state();
    end
    @(posedge clock);
    stop_request <= 1'b1;
    @(posedge clock);
    stop_request <= 1'b0;
    tick(2);
    // The ramp starts from the setpoint and loses one step per clock.
    m_spd = sp - 2;
    check_state();
    cmp(20'h00001, {19'h0, speed_demand_q < sp[15:0] && speed_demand_q > 16'h0000});
    for (int i = 0; i < 300 && motor_power_q !== 1'b0; i++) @(posedge clock);
    m_pow = 0;
    m_spd = 0;
    check_state();
    restart();
    demand(1, 0, 3);
    demand(1, 1, 8);
    check_state();
    @(posedge clock);
    run_request <= 1'b1;
    tick(10 * PAIR);
    check_state();
    @(posedge clock);
    run_request <= 1'b0;
    demand(0, 0, 8);
    check_state();
    restart();
    check_state();
    end_sim();
  end
endmodule
